// *** design/rso_switchover.sv ***
// Reference switchover controller with AHB-Lite register slave
// Assumes reference status inputs are synchronous to hclk
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "rso_regs.svh"

module rso_switchover
(
	// AHB-Lite
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic      [31:0]      hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	// Reference status
	input  wire logic             primary_reference_ok,
	input  wire logic             secondary_reference_ok,
	input  wire logic             clk_freq_ok,
	input  wire logic             digital_lock_detect,
	input  wire logic             lock_detect_pin,
	input  wire logic             holdover_active,
	input  wire logic             reference_select_pin,
	// Reference control and monitor
	output logic                  pll_ref_sel_secondary,
	output logic                  primary_ref_power_en,
	output logic                  secondary_ref_power_en,
	output logic                  deglitch_active,
	output logic                  reference_monitor_pin,
	output logic                  irq
);
	import rso_pkg::*;
	default clocking dflt_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	localparam logic [3:0] DG_LAST = 4'(`RSO_DG_CYC - 1);

	// ****************************************
	// Registers
	// ****************************************
	rso_byte_t        ctrl_reg, ctrl_next;
	logic [4:0]       monsel_reg, monsel_next;
	logic [1:0]       stat_reg, stat_next;
	logic [1:0]       mask_reg, mask_next;
	rso_state_t       state_reg, state_next;
	logic             sel_reg, sel_next;
	logic [3:0]       dg_cnt_reg, dg_cnt_next;
	logic             mon_reg, mon_next;
	logic             wr_pend_reg;
	logic [7:0]       wr_addr_reg;
	logic [31:0]      rdata_reg, rdata_next;

	function automatic logic [31:0] rso_zext8(input logic [7:0] v);
		rso_zext8 = {24'h00_0000, v};
	endfunction : rso_zext8

	// ****************************************
	// Bus decode
	// ****************************************
	wire        addr_phase = hsel & htrans[1] & hready;
	wire        rd_take    = addr_phase & ~hwrite;
	wire [7:0]  rd_addr    = haddr[7:0];
	wire        wr_ctrl    = wr_pend_reg & (wr_addr_reg == `RSO_OFS_CTRL);
	wire        wr_monsel  = wr_pend_reg & (wr_addr_reg == `RSO_OFS_MONSEL);
	wire        wr_stat    = wr_pend_reg & (wr_addr_reg == `RSO_OFS_IRQ_STAT);
	wire        wr_mask    = wr_pend_reg & (wr_addr_reg == `RSO_OFS_IRQ_MASK);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;

	// ****************************************
	// Selection logic
	// ****************************************
	wire auto_en   = ctrl_reg[`RSO_CTRL_AUTO];
	wire stay_sec  = ctrl_reg[`RSO_CTRL_STAY];
	wire dg_bypass = ctrl_reg[`RSO_CTRL_DG_OFF];
	// Manual source: register bit or select pin
	wire man_sel   = ctrl_reg[`RSO_CTRL_USE_PIN] ? reference_select_pin
		: ctrl_reg[`RSO_CTRL_SEL_SEC];
	wire req_sel   = auto_en ? (state_reg == RSO_ST_SEC)
		: man_sel;
	wire sel_ok    = sel_reg ? secondary_reference_ok : primary_reference_ok;

	always_comb
	begin
		state_next = state_reg;
		if (!auto_en)
			// Track manual choice so entering auto starts from it
			state_next = man_sel ? RSO_ST_SEC : RSO_ST_PRI;
		else
			case (state_reg)
				RSO_ST_PRI:
				begin
					if (!primary_reference_ok && secondary_reference_ok)
						state_next = RSO_ST_SEC;
				end
				RSO_ST_SEC:
				begin
					if (!stay_sec && primary_reference_ok)
						state_next = RSO_ST_PRI;
					// Stay-on-secondary holds here
				end
				default: state_next = RSO_ST_PRI;
			endcase
	end

	// Deglitch: a change must stand for the deglitch time
	wire sel_diff = (req_sel != sel_reg);
	assign dg_cnt_next = (!sel_diff || dg_bypass) ? 4'h0
		: (dg_cnt_reg == DG_LAST) ? 4'h0 : dg_cnt_reg + 4'h1;
	assign sel_next = (sel_diff && (dg_bypass || dg_cnt_reg == DG_LAST))
		? req_sel : sel_reg;

	// ****************************************
	// Monitor pin
	// ****************************************
	always_comb
	begin
		case (monsel_reg)
			`RSO_MON_LOCK_ALL:
				mon_next = digital_lock_detect & sel_ok & clk_freq_ok;
			`RSO_MON_CLK_N:
				mon_next = ~clk_freq_ok;
			`RSO_MON_SEL_REF:
				mon_next = ~sel_reg;
			`RSO_MON_LOCK_N:
				mon_next = ~digital_lock_detect;
			`RSO_MON_HOLD_N:
				mon_next = ~holdover_active;
			`RSO_MON_LDPIN_N:
				mon_next = ~lock_detect_pin;
			default: mon_next = 1'b0;
		endcase
	end

	// ****************************************
	// Register writes and events
	// ****************************************
	wire [1:0] evt;
	assign evt[`RSO_IRQ_SEL_CHG] = (sel_next != sel_reg);
	assign evt[`RSO_IRQ_AUTO_SW] = auto_en & (state_reg == RSO_ST_PRI)
		& (state_next == RSO_ST_SEC);

	assign ctrl_next   = wr_ctrl ? hwdata[7:0] : ctrl_reg;
	assign monsel_next = wr_monsel ? hwdata[4:0] : monsel_reg;
	assign mask_next   = wr_mask ? hwdata[1:0] : mask_reg;
	// Set wins over write-one-to-clear
	assign stat_next   = (stat_reg & ~(wr_stat ? hwdata[1:0] : 2'b00)) | evt;

	// Read data from next values so a write just before is seen
	always_comb
	begin
		case (rd_addr)
			`RSO_OFS_CTRL:     rdata_next = rso_zext8(ctrl_next);
			`RSO_OFS_MONSEL:   rdata_next = rso_zext8({3'h0, monsel_next});
			`RSO_OFS_IRQ_STAT: rdata_next = rso_zext8({6'h00, stat_next});
			`RSO_OFS_IRQ_MASK: rdata_next = rso_zext8({6'h00, mask_next});
			`RSO_OFS_STATE:    rdata_next = rso_zext8({4'h0, irq,
				secondary_ref_power_en, primary_ref_power_en, sel_reg});
			default:           rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg   <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_reg <= addr_phase & hwrite;
			wr_addr_reg <= haddr[7:0];
			if (rd_take)
				rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg   <= `RSO_CTRL_RESET;
			monsel_reg <= `RSO_MONSEL_RESET;
			stat_reg   <= 2'b00;
			mask_reg   <= 2'b00;
			state_reg  <= RSO_ST_PRI;
			sel_reg    <= 1'b0;
			dg_cnt_reg <= 4'h0;
			mon_reg    <= 1'b0;
		end
		else
		begin
			ctrl_reg   <= ctrl_next;
			monsel_reg <= monsel_next;
			stat_reg   <= stat_next;
			mask_reg   <= mask_next;
			state_reg  <= state_next;
			sel_reg    <= sel_next;
			dg_cnt_reg <= dg_cnt_next;
			mon_reg    <= mon_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign pll_ref_sel_secondary  = sel_reg;
	assign reference_monitor_pin  = mon_reg;
	assign deglitch_active        = ~dg_bypass;
	assign primary_ref_power_en   = auto_en
		| ctrl_reg[`RSO_CTRL_PRI_PWR];
	assign secondary_ref_power_en = auto_en
		| ctrl_reg[`RSO_CTRL_SEC_PWR];
	assign irq = |(stat_reg & mask_reg);

	// ****************************************
	// Assertions
	// ****************************************
	property p_mon_lock_all;
		monsel_reg == `RSO_MON_LOCK_ALL |=> reference_monitor_pin ==
			($past(digital_lock_detect) & $past(sel_ok) & $past(clk_freq_ok));
	endproperty
	a_mon_lock_all: assert property (p_mon_lock_all)
		else $error("monitor lock-all level wrong");

	property p_mon_clk_n;
		monsel_reg == `RSO_MON_CLK_N ##1 monsel_reg == `RSO_MON_CLK_N
			|-> reference_monitor_pin != $past(clk_freq_ok);
	endproperty
	a_mon_clk_n: assert property (p_mon_clk_n)
		else $error("monitor clock status not active low");

	property p_mon_sel;
		monsel_reg == `RSO_MON_SEL_REF |=>
			reference_monitor_pin == !$past(pll_ref_sel_secondary);
	endproperty
	a_mon_sel: assert property (p_mon_sel)
		else $error("monitor selected reference level wrong");

	property p_mon_lock_hold;
		(monsel_reg == `RSO_MON_LOCK_N && digital_lock_detect) ||
		(monsel_reg == `RSO_MON_HOLD_N && holdover_active)
			|=> !reference_monitor_pin;
	endproperty
	a_mon_lock_hold: assert property (p_mon_lock_hold)
		else $error("monitor lock or holdover not active low");

	property p_mon_ldpin;
		monsel_reg == `RSO_MON_LDPIN_N |=>
			reference_monitor_pin == !$past(lock_detect_pin);
	endproperty
	a_mon_ldpin: assert property (p_mon_ldpin)
		else $error("monitor lock pin not active low");

	property p_deglitch;
		!dg_bypass && sel_diff && dg_cnt_reg == 4'h0 ##1 !dg_bypass
			|-> $stable(pll_ref_sel_secondary);
	endproperty
	a_deglitch: assert property (p_deglitch)
		else $error("selection changed inside deglitch time");

	property p_manual_reg;
		!auto_en && !ctrl_reg[`RSO_CTRL_USE_PIN] && dg_bypass
			&& !$changed(ctrl_reg) |-> pll_ref_sel_secondary ==
			$past(ctrl_reg[`RSO_CTRL_SEL_SEC]);
	endproperty
	a_manual_reg: assert property (p_manual_reg)
		else $error("register selection not followed");

	property p_manual_pin;
		!auto_en && ctrl_reg[`RSO_CTRL_USE_PIN] && dg_bypass
			|=> pll_ref_sel_secondary == $past(reference_select_pin);
	endproperty
	a_manual_pin: assert property (p_manual_pin)
		else $error("select pin not followed");

	property p_auto_switch;
		auto_en && state_reg == RSO_ST_PRI && !primary_reference_ok
			&& secondary_reference_ok |=> state_reg == RSO_ST_SEC;
	endproperty
	a_auto_switch: assert property (p_auto_switch)
		else $error("automatic switchover missed");

	property p_auto_power;
		auto_en |-> primary_ref_power_en && secondary_ref_power_en;
	endproperty
	a_auto_power: assert property (p_auto_power)
		else $error("auto mode left a reference unpowered");

	property p_revert;
		auto_en && !stay_sec && state_reg == RSO_ST_SEC
			&& primary_reference_ok |=> state_reg == RSO_ST_PRI;
	endproperty
	a_revert: assert property (p_revert)
		else $error("no revert to primary");

	property p_stay;
		auto_en && stay_sec && state_reg == RSO_ST_SEC ##1 auto_en
			|-> state_reg == RSO_ST_SEC;
	endproperty
	a_stay: assert property (p_stay)
		else $error("non-revertive mode returned to primary");

	property p_sec_power;
		!auto_en |-> secondary_ref_power_en == ctrl_reg[`RSO_CTRL_SEC_PWR];
	endproperty
	a_sec_power: assert property (p_sec_power)
		else $error("secondary power bit not followed");

	property p_cov_auto_sw;
		auto_en && state_reg == RSO_ST_PRI ##1 state_reg == RSO_ST_SEC;
	endproperty
	c_auto_sw: cover property (p_cov_auto_sw);

	property p_cov_revert;
		auto_en && state_reg == RSO_ST_SEC ##1 state_reg == RSO_ST_PRI;
	endproperty
	c_revert: cover property (p_cov_revert);

	property p_cov_irq;
		!irq ##1 irq;
	endproperty
	c_irq: cover property (p_cov_irq);

endmodule : rso_switchover

// *** include/rso_regs.svh ***
// Register map, field positions, reset values and timing counts
// Assumes a 125 MHz hclk and word-aligned AHB-Lite accesses
`ifndef RSO_REGS_SVH
`define RSO_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define RSO_OFS_CTRL     8'h1c
`define RSO_OFS_MONSEL   8'h20
`define RSO_OFS_IRQ_STAT 8'h24
`define RSO_OFS_IRQ_MASK 8'h28
`define RSO_OFS_STATE    8'h2c

// ****************************************
// Control fields
// ****************************************
`define RSO_CTRL_DIFF     0
`define RSO_CTRL_PRI_PWR  1
`define RSO_CTRL_SEC_PWR  2
`define RSO_CTRL_STAY     3
`define RSO_CTRL_AUTO     4
`define RSO_CTRL_USE_PIN  5
`define RSO_CTRL_SEL_SEC  6
`define RSO_CTRL_DG_OFF   7
`define RSO_CTRL_RESET    8'h00
`define RSO_MONSEL_RESET  5'h00

// ****************************************
// Monitor selection codes
// ****************************************
`define RSO_MON_LOCK_ALL  5'h1a
`define RSO_MON_CLK_N     5'h1b
`define RSO_MON_SEL_REF   5'h1c
`define RSO_MON_LOCK_N    5'h1d
`define RSO_MON_HOLD_N    5'h1e
`define RSO_MON_LDPIN_N   5'h1f

// ****************************************
// Interrupt bits and timing
// ****************************************
`define RSO_IRQ_SEL_CHG   0
`define RSO_IRQ_AUTO_SW   1
`define RSO_CLK_NS        8
`define RSO_DG_NS         64
`define RSO_DG_CYC        ((`RSO_DG_NS + `RSO_CLK_NS - 1) / `RSO_CLK_NS)

`endif

// *** include/rso_pkg.sv ***
// Types for the reference switchover block
// Assumes rso_regs.svh is compiled alongside
package rso_pkg;

	typedef enum logic [1:0]
	{
		RSO_ST_PRI = 2'b01,
		RSO_ST_SEC = 2'b10
	} rso_state_t;

	typedef logic [7:0] rso_byte_t;

endpackage : rso_pkg

// *** sim/rso_ref_model.sv ***
// Model of the two external reference sources
// Assumes the bench commands failures and the design powers the inputs
`timescale 1ns/100ps

module rso_ref_model
(
	// Power from the design
	input  wire logic primary_ref_power_en,
	input  wire logic secondary_ref_power_en,
	// Failure commands from the bench
	input  wire logic primary_fail,
	input  wire logic secondary_fail,
	// Status seen by the design
	output logic      primary_reference_ok,
	output logic      secondary_reference_ok
);
	// An unpowered input never reports a good reference
	assign primary_reference_ok   = primary_ref_power_en &
		~primary_fail;
	assign secondary_reference_ok = secondary_ref_power_en &
		~secondary_fail;
endmodule : rso_ref_model

// *** sim/tb.sv ***
// Self-checking bench for the reference switchover block
// Assumes one AHB-Lite master, zero-wait slave, 125 MHz hclk
`timescale 1ns/100ps
`include "rso_regs.svh"

module tb;
	typedef struct packed
	{
		logic [4:0] code;
		logic [5:0] bits;
	} rso_row_t;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [6:0]  st = 7'h00;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, sel_sec, pri_pwr, sec_pwr;
	wire         dg, mon, irq, pri_ok, sec_ok;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	// Fields: code, lock detect, lock pin, holdover, clk ok, primary fail, exp
	rso_row_t    rows [14] = '{
		{5'h1a, 6'b100101}, {5'h1a, 6'b100110}, {5'h1a, 6'b000100},
		{5'h1a, 6'b100000}, {5'h1b, 6'b000100}, {5'h1b, 6'b000001},
		{5'h1c, 6'b000001}, {5'h1d, 6'b100000}, {5'h1d, 6'b000001},
		{5'h1e, 6'b001000}, {5'h1e, 6'b000001}, {5'h1f, 6'b010000},
		{5'h1f, 6'b000001}, {5'h19, 6'b111100}};

	always #4 hclk = ~hclk;

	rso_switchover rso_switchover_inst
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.primary_reference_ok(pri_ok), .secondary_reference_ok(sec_ok),
		.clk_freq_ok(st[3]), .digital_lock_detect(st[6]),
		.lock_detect_pin(st[5]), .holdover_active(st[4]),
		.reference_select_pin(st[0]), .pll_ref_sel_secondary(sel_sec),
		.primary_ref_power_en(pri_pwr), .secondary_ref_power_en(sec_pwr),
		.deglitch_active(dg), .reference_monitor_pin(mon), .irq(irq)
	);

	rso_ref_model rso_ref_model_inst
	(
		.primary_ref_power_en(pri_pwr), .secondary_ref_power_en(sec_pwr),
		.primary_fail(st[2]), .secondary_fail(st[1]),
		.primary_reference_ok(pri_ok), .secondary_reference_ok(sec_ok)
	);

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wait_rdy;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		n_mismatch++;
		tally_and_finish;
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [7:0] a, d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		wait_rdy;
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(what, q, exp);
	endtask : rd_chk

	task automatic edges(input int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask : edges

	task automatic wait_sel(input logic e);
		for (int i = 0; i < 40; i++)
		begin
			@(negedge hclk);
			if (sel_sec === e)
				return;
		end
		n_mismatch++;
		tally_and_finish;
	endtask : wait_sel

	task automatic outs_reset;
		chk("hrdata", hrdata, 32'h0000_0000);
		chk("hready", {hreadyout, hresp}, 32'h0000_0002);
		chk("sel", sel_sec, 32'h0000_0000);
		chk("power", {pri_pwr, sec_pwr}, 32'h0000_0000);
		chk("deglitch", dg, 32'h0000_0001);
		chk("mon irq", {mon, irq}, 32'h0000_0000);
	endtask : outs_reset

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		edges(0);
		outs_reset;
		rd_chk("ctrl", `RSO_OFS_CTRL, 32'h0000_0000);
		rd_chk("monsel", `RSO_OFS_MONSEL, 32'h0000_0000);
		rd_chk("mask", `RSO_OFS_IRQ_MASK, 32'h0000_0000);
		wr(8'h40, 8'hff);
		rd_chk("unmapped", 8'h40, 32'h0000_0000);
		wr(`RSO_OFS_CTRL, 8'h02);
		foreach (rows[i])
		begin
			wr(`RSO_OFS_MONSEL, {3'h0, rows[i].code});
			st[6:2] <= rows[i].bits[5:1];
			edges(2);
			chk("monitor", mon, rows[i].bits[0]);
		end
		// Manual register selection with deglitch bypassed
		@(posedge hclk);
		st <= 7'h00;
		wr(`RSO_OFS_MONSEL, 8'h1c);
		wr(`RSO_OFS_IRQ_MASK, 8'h01);
		wr(`RSO_OFS_CTRL, 8'hc0);
		edges(0);
		chk("deglitch", {dg, sel_sec}, 32'h0000_0000);
		edges(1);
		chk("sel", sel_sec, 32'h0000_0001);
		edges(1);
		chk("mon irq", {mon, irq}, 32'h0000_0001);
		rd_chk("stat", `RSO_OFS_IRQ_STAT, 32'h0000_0001);
		wr(`RSO_OFS_IRQ_STAT, 8'h01);
		edges(1);
		chk("irq", irq, 32'h0000_0000);
		// Pin selection overrides bit 6, interrupt masked
		wr(`RSO_OFS_IRQ_MASK, 8'h00);
		wr(`RSO_OFS_CTRL, 8'he0);
		wait_sel(1'b0);
		chk("pin sel", sel_sec, 32'h0000_0000);
		@(posedge hclk);
		st[0] <= 1'b1;
		wait_sel(1'b1);
		chk("pin sel irq", {sel_sec, irq}, 32'h0000_0002);
		// Deglitch holds off a pin change for a while
		wr(`RSO_OFS_CTRL, 8'h20);
		st[0] <= 1'b0;
		edges(3);
		chk("held", {dg, sel_sec}, 32'h0000_0003);
		edges(`RSO_DG_CYC - 4);
		chk("held last", sel_sec, 32'h0000_0001);
		edges(1);
		chk("deglitch end", sel_sec, 32'h0000_0000);
		wr(`RSO_OFS_CTRL, 8'h04);
		edges(0);
		chk("power", {pri_pwr, sec_pwr}, 32'h0000_0001);
		// Automatic switchover, single-ended mode kept
		wr(`RSO_OFS_IRQ_STAT, 8'h03);
		wr(`RSO_OFS_CTRL, 8'h90);
		edges(0);
		chk("auto power", {pri_pwr, sec_pwr}, 32'h0000_0003);
		@(posedge hclk);
		st[2] <= 1'b1;
		wait_sel(1'b1);
		chk("auto sw", sel_sec, 32'h0000_0001);
		rd_chk("stat", `RSO_OFS_IRQ_STAT, 32'h0000_0003);
		st[2] <= 1'b0;
		wait_sel(1'b0);
		chk("revert", sel_sec, 32'h0000_0000);
		wr(`RSO_OFS_CTRL, 8'h98);
		st[2] <= 1'b1;
		wait_sel(1'b1);
		@(posedge hclk);
		st[2] <= 1'b0;
		edges(20);
		chk("stay", sel_sec, 32'h0000_0001);
		rd_chk("state", `RSO_OFS_STATE, 32'h0000_0007);
		// Second reset in mid-run
		@(posedge hclk);
		hresetn <= 1'b0;
		edges(1);
		outs_reset;
		@(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("ctrl", `RSO_OFS_CTRL, 32'h0000_0000);
		tally_and_finish;
	end
endmodule : tb
